// >>> dbfc_pkg.sv
// Purpose: Constants and types of the data block to flag copier.
// Assumes: One clock; the sequencer holds operands beside the start pulse.
// Notes: Register offsets are word indices on the plain register port.
//
// Contract
// - Write general flag bytes only, from open block.
// - Read consecutive words from start index onward.
// - Byte-wise and word-wise modes, otherwise identical.
// - Success clears result flag, accumulators untouched.
// - Fault sets result flag, accumulators untouched.
// - Fault when no data block is open.
// - Fault when last flag below first flag.
// - Fault when start word index does not exist.
// - Fault when block too short for range.

package dbfc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned REG_AW = 4;
  localparam int unsigned REG_DW = 8;
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_MASK = 4'h1;
  localparam logic [3:0] OFS_INFO = 4'h2;
  localparam logic [3:0] OFS_CTRL = 4'h3;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned STS_DONE_BIT = 0;
  localparam int unsigned STS_FAULT_BIT = 1;
  localparam int unsigned INFO_BUSY_BIT = 0;
  localparam int unsigned INFO_RLO_BIT = 1;
  localparam int unsigned INFO_MODE_BIT = 2;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam logic RLO_RESET = 1'b0;

  // Mode select: low is byte-wise, high is word-wise.
  localparam logic MODE_BYTEWISE = 1'b0;
  localparam logic MODE_WORDWISE = 1'b1;

  // ----------------------------------------------------------------
  // Engine states, Gray coded from ST_IDLE through ST_WR1 to ST_FIN
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CHK = 3'h1,
    ST_RD = 3'h3,
    ST_WT = 3'h2,
    ST_WR0 = 3'h6,
    ST_WR1 = 3'h7,
    ST_FIN = 3'h5
  } dbfc_state_e;

endpackage : dbfc_pkg

// >>> dbfc_op_if.sv
// Purpose: Operand bundle between the engine and its operand checker.
// Assumes: Operands are held stable in registers while checked.
// Notes: Purely combinational path, no state.
`timescale 1ns/1ps
`default_nettype none

interface dbfc_op_if #(
  parameter int unsigned DW_W = 16
);
  logic blk_open;
  logic [DW_W-1:0] blk_len;
  logic [DW_W-1:0] start_idx;
  logic [7:0] first_flag;
  logic [7:0] last_flag;
  logic fault;
  logic [8:0] n_words;

  modport engine (
    output blk_open, blk_len, start_idx, first_flag, last_flag,
    input fault, n_words
  );
  modport checker_side (
    input blk_open, blk_len, start_idx, first_flag, last_flag,
    output fault, n_words
  );
endinterface : dbfc_op_if

`default_nettype wire

// >>> dbfc_check.sv
// Purpose: Validates transfer operands and sizes the source range.
// Assumes: Inputs come from registers of the engine.
// Notes: Widened sums avoid wrap at the top of the word index range.
`timescale 1ns/1ps
`default_nettype none

module dbfc_check #(
  parameter int unsigned DW_W = 16
) (
  // Operands and verdict
  dbfc_op_if.checker_side op
);

  logic [8:0] n_bytes;
  logic [DW_W:0] end_idx;

  always_comb
  begin
    // Byte count and rounded-up word count.
    // range sizing
    n_bytes = {1'b0, op.last_flag} - {1'b0, op.first_flag} + 9'h001;
    op.n_words = (n_bytes + 9'h001) >> 1;
    end_idx = {1'b0, op.start_idx} + {{(DW_W - 8){1'b0}}, op.n_words};
    op.fault = 1'b0;
    if (!op.blk_open)
    begin
      op.fault = 1'b1;
    end
    if (op.last_flag < op.first_flag)
    begin
      op.fault = 1'b1;
    end
    if (op.start_idx >= op.blk_len)
    begin
      op.fault = 1'b1;
    end
    if (end_idx > {1'b0, op.blk_len})
    begin
      op.fault = 1'b1;
    end
  end

endmodule : dbfc_check

`default_nettype wire

// >>> dbfc_top.sv
// Purpose: Copies data block words into the general flag byte area.
// Assumes: Block memory answers a read one cycle later; same clock.
// Notes: Accumulators are inputs only, so they can never be altered.
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module dbfc_top
  import dbfc_pkg::*;
#(
  parameter int unsigned DW_W = 16
) (
  // Clock, reset, enable
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  // Register port
  input wire logic [REG_AW-1:0] REG_ADDR_I,
  input wire logic [REG_DW-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [REG_DW-1:0] REG_RDATA_O,
  // Call from the sequencer
  input wire logic START_I,
  input wire logic MODE_I,
  input wire logic [15:0] SECOND_ACCUMULATOR_LOW_WORD_I,
  input wire logic [7:0] FIRST_ACCUMULATOR_LOW_HIGH_BYTE_I,
  input wire logic [7:0] FIRST_ACCUMULATOR_LOW_LOW_BYTE_I,
  output logic BUSY_O,
  output logic DONE_O,
  output logic RESULT_LOGIC_FLAG_O,
  // Open data block
  input wire logic BLOCK_OPEN_I,
  input wire logic [DW_W-1:0] BLOCK_LEN_I,
  output logic BLOCK_RD_O,
  output logic [DW_W-1:0] BLOCK_ADDR_O,
  input wire logic [15:0] BLOCK_RDATA_I,
  // General flag byte area
  output logic FLAG_WR_O,
  output logic [7:0] FLAG_ADDR_O,
  output logic [7:0] FLAG_WDATA_O,
  // Interrupt
  output logic IRQ_O
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DW_W < 9 || DW_W > 16)
  begin : g_bad_width
    $error("DW_W must lie between 9 and 16");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dbfc_state_e st;
    logic mode;
    logic blk_open;
    logic [DW_W-1:0] blk_len;
    logic [DW_W-1:0] start;
    logic [DW_W-1:0] word;
    logic [7:0] first;
    logic [7:0] last;
    logic [7:0] ptr;
    logic [15:0] data;
    logic fault;
    logic rd;
    logic [DW_W-1:0] addr;
    logic fwr;
    logic [7:0] faddr;
    logic [7:0] fdata;
    logic busy;
    logic done;
    logic result_logic_flag;
    logic irq;
    logic [1:0] sts;
    logic [1:0] mask;
    logic en;
    logic [REG_DW-1:0] rdata;
  } dbfc_state_s;

  localparam dbfc_state_s RESET_S = '{
    st: ST_IDLE,
    mode: MODE_BYTEWISE,
    result_logic_flag: RLO_RESET,
    mask: MASK_RESET,
    en: CTRL_EN_RESET,
    default: '0
  };

  dbfc_state_s s_q;
  dbfc_state_s s_d;
  logic [1:0] sts_set;
  logic [1:0] sts_clr;

  dbfc_op_if #(.DW_W(DW_W)) op ();

  assign op.blk_open = s_q.blk_open;
  assign op.blk_len = s_q.blk_len;
  assign op.start_idx = s_q.start;
  assign op.first_flag = s_q.first;
  assign op.last_flag = s_q.last;

  dbfc_check #(.DW_W(DW_W)) u_check (
    .op(op)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.rd = 1'b0;
    s_d.fwr = 1'b0;
    s_d.done = 1'b0;
    s_d.rdata = '0;
    sts_set = 2'h0;
    sts_clr = 2'h0;
    case (s_q.st)
      ST_IDLE:
      begin
        if (START_I && s_q.en)
        begin
          s_d.start = SECOND_ACCUMULATOR_LOW_WORD_I[DW_W-1:0];
          s_d.fault = (SECOND_ACCUMULATOR_LOW_WORD_I >> DW_W) != 16'h0000;
          s_d.first = FIRST_ACCUMULATOR_LOW_HIGH_BYTE_I;
          s_d.last = FIRST_ACCUMULATOR_LOW_LOW_BYTE_I;
          s_d.mode = MODE_I;
          s_d.blk_open = BLOCK_OPEN_I;
          s_d.blk_len = BLOCK_LEN_I;
          s_d.busy = 1'b1;
          s_d.st = ST_CHK;
        end
      end
      ST_CHK:
      begin
        // Indexes wider than the block port cannot exist in the block.
        s_d.fault = op.fault | s_q.fault;
        s_d.word = s_q.start;
        s_d.ptr = s_q.first;
        s_d.st = s_d.fault ? ST_FIN : ST_RD;
      end
      ST_RD:
      begin
        s_d.rd = 1'b1;
        s_d.addr = s_q.word;
        s_d.st = ST_WT;
      end
      ST_WT:
      begin
        // The block memory answers one cycle after the read strobe.
        s_d.st = ST_WR0;
      end
      ST_WR0:
      begin
        s_d.data = BLOCK_RDATA_I;
        s_d.fwr = 1'b1;
        s_d.faddr = s_q.ptr;
        s_d.fdata = (s_q.mode == MODE_WORDWISE) ? BLOCK_RDATA_I[15:8]
                                                 : BLOCK_RDATA_I[7:0];
        s_d.ptr = s_q.ptr + 8'h01;
        s_d.st = (s_q.ptr == s_q.last) ? ST_FIN : ST_WR1;
      end
      ST_WR1:
      begin
        s_d.fwr = 1'b1;
        s_d.faddr = s_q.ptr;
        s_d.fdata = (s_q.mode == MODE_WORDWISE) ? s_q.data[7:0]
                                                 : s_q.data[15:8];
        s_d.ptr = s_q.ptr + 8'h01;
        s_d.word = s_q.word + {{(DW_W - 1){1'b0}}, 1'b1};
        s_d.st = (s_q.ptr == s_q.last) ? ST_FIN : ST_RD;
      end
      ST_FIN:
      begin
        s_d.result_logic_flag = s_q.fault;
        s_d.done = 1'b1;
        s_d.busy = 1'b0;
        sts_set[STS_DONE_BIT] = 1'b1;
        sts_set[STS_FAULT_BIT] = s_q.fault;
        s_d.st = ST_IDLE;
      end
      default:
      begin
        s_d.st = ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase

    // Register writes; a status event in the same cycle beats the clear.
    if (REG_WR_I)
    begin
      case (REG_ADDR_I)
        OFS_STATUS: sts_clr = REG_WDATA_I[1:0];
        OFS_MASK: s_d.mask = REG_WDATA_I[1:0];
        OFS_CTRL: s_d.en = REG_WDATA_I[CTRL_EN_BIT];
        default: sts_clr = 2'h0;
      endcase
    end
    s_d.sts = (s_q.sts & ~sts_clr) | sts_set;
    s_d.irq = |(s_d.sts & s_d.mask);

    // Reads answer in the next cycle; unmapped offsets read zero.
    if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        OFS_STATUS: s_d.rdata = {6'h00, s_q.sts};
        OFS_MASK: s_d.rdata = {6'h00, s_q.mask};
        OFS_INFO:
        begin
          s_d.rdata[INFO_BUSY_BIT] = s_q.busy;
          s_d.rdata[INFO_RLO_BIT] = s_q.result_logic_flag;
          s_d.rdata[INFO_MODE_BIT] = s_q.mode;
        end
        OFS_CTRL: s_d.rdata[CTRL_EN_BIT] = s_q.en;
        default: s_d.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!NRST_I)
    begin
      s_q <= RESET_S;
    end
    else if (CE_I)
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REG_RDATA_O = s_q.rdata;
  assign BUSY_O = s_q.busy;
  assign DONE_O = s_q.done;
  assign RESULT_LOGIC_FLAG_O = s_q.result_logic_flag;
  assign BLOCK_RD_O = s_q.rd;
  assign BLOCK_ADDR_O = s_q.addr;
  assign FLAG_WR_O = s_q.fwr;
  assign FLAG_ADDR_O = s_q.faddr;
  assign FLAG_WDATA_O = s_q.fdata;
  assign IRQ_O = s_q.irq;

endmodule : dbfc_top

`default_nettype wire

// >>> dbfc_mem.sv
// Purpose: Open data block memory facing the copier.
// Assumes: A read is answered one cycle later.
// Notes: Outside a read the data lines toggle, so stale data never match.
`timescale 1ns/1ps
`default_nettype none
module dbfc_mem (
  // Clock and read request
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  // Read data
  output logic [15:0] rdata_o
);
  always_ff @(posedge clk_i)
  begin
    if (rd_i)
      rdata_o <= {addr_i[7:0] ^ 8'h5A, addr_i[7:0] ^ 8'hC3};
    else
      rdata_o <= ~rdata_o;
  end
endmodule : dbfc_mem
`default_nettype wire

// >>> dbfc_chk.sv
// Purpose: Timing and operand checks of the copier.
// Assumes: Copy enable left set, so a call in idle is always taken.
// Notes: Operands are captured as the call is taken.
`timescale 1ns/1ps
`default_nettype none
module dbfc_chk
  import dbfc_pkg::*;
#(
  parameter int unsigned DW_W = 16
) (
  // Call side
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire logic START_I,
  input wire logic [15:0] SECOND_ACCUMULATOR_LOW_WORD_I,
  input wire logic [7:0] FIRST_ACCUMULATOR_LOW_HIGH_BYTE_I,
  input wire logic [7:0] FIRST_ACCUMULATOR_LOW_LOW_BYTE_I,
  input wire logic BUSY_O,
  input wire logic DONE_O,
  input wire logic RESULT_LOGIC_FLAG_O,
  // Block and flag sides
  input wire logic BLOCK_OPEN_I,
  input wire logic [DW_W-1:0] BLOCK_LEN_I,
  input wire logic BLOCK_RD_O,
  input wire logic [DW_W-1:0] BLOCK_ADDR_O,
  input wire logic FLAG_WR_O,
  input wire logic [7:0] FLAG_ADDR_O
);
  wire tk = START_I && CE_I && !BUSY_O;
  wire [7:0] fb = FIRST_ACCUMULATOR_LOW_HIGH_BYTE_I;
  wire [7:0] lb = FIRST_ACCUMULATOR_LOW_LOW_BYTE_I;
  wire [DW_W:0] sw = {1'b0, SECOND_ACCUMULATOR_LOW_WORD_I[DW_W-1:0]};
  wire [DW_W:0] need = sw + (DW_W+1)'((lb - fb) >> 1) + 1'b1;
  wire [DW_W:0] len = {1'b0, BLOCK_LEN_I};
  logic [7:0] f_q, l_q;
  logic [DW_W-1:0] s_q, r_q;
  logic [8:0] w_q;
  always_ff @(posedge CORE_CLK_I)
  begin
    if (tk)
    begin
      f_q <= fb;
      l_q <= lb;
      s_q <= sw[DW_W-1:0];
      r_q <= '0;
      w_q <= '0;
    end
    else
    begin
      r_q <= r_q + DW_W'(BLOCK_RD_O);
      w_q <= w_q + 9'(FLAG_WR_O);
    end
  end
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!NRST_I);
  sequence s_flt;
    ##3 DONE_O && RESULT_LOGIC_FLAG_O;
  endsequence
  a_no_block: assert property (
    tk && !BLOCK_OPEN_I |-> s_flt) else $error("closed block not refused");
  a_bad_range: assert property (
    tk && BLOCK_OPEN_I && lb < fb |-> s_flt) else $error("range not refused");
  a_bad_start: assert property (
    tk && BLOCK_OPEN_I && sw >= len |-> s_flt) else $error("start not refused");
  a_too_short: assert property (
    tk && BLOCK_OPEN_I && lb >= fb && need > len |-> s_flt)
    else $error("short block not refused");
  a_ok_count: assert property (
    DONE_O && !RESULT_LOGIC_FLAG_O |-> w_q == 9'(l_q) - 9'(f_q) + 9'h1)
    else $error("flag write count wrong");
  a_flag_addr: assert property (
    FLAG_WR_O |-> FLAG_ADDR_O == f_q + w_q[7:0] && FLAG_ADDR_O <= l_q)
    else $error("flag address wrong");
  a_src_addr: assert property (
    BLOCK_RD_O |-> BLOCK_ADDR_O == s_q + r_q) else $error("source address");
  a_read_write: assert property (
    BLOCK_RD_O |-> ##2 FLAG_WR_O) else $error("read not followed by write");
  a_flag_hold: assert property (
    !$stable(RESULT_LOGIC_FLAG_O) |-> DONE_O) else $error("flag moved");
  c_ok: cover property (DONE_O && !RESULT_LOGIC_FLAG_O);
  c_fault: cover property (DONE_O && RESULT_LOGIC_FLAG_O);
  c_pair: cover property (FLAG_WR_O ##1 FLAG_WR_O);
endmodule : dbfc_chk
bind dbfc_top dbfc_chk #(.DW_W(DW_W)) u_chk (.*);
`default_nettype wire

// >>> tb.sv
// Purpose: Self-checking bench for the data block to flag copier.
// Assumes: Clock enable held high; block memory is dbfc_mem.
// Notes: Drivers queue expected results; one monitor compares them.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dbfc_pkg::*;
  logic clk, rst_n, st, md, op, wr, rd, fw, dn, result_logic_flag, by, brd, irq, rp;
  logic [3:0] ra;
  logic [7:0] wd, rq, f1, l1, fa, fd, rf;
  logic [15:0] sa, ln, ba, bd;
  logic [15:0] qf[$], qd[$], qr[$];
  int n_mismatch = 0;
  int check_count = 0;
  dbfc_top dut (
    .CORE_CLK_I(clk), .NRST_I(rst_n), .CE_I(1'b1),
    .REG_ADDR_I(ra), .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rq), .START_I(st), .MODE_I(md),
    .SECOND_ACCUMULATOR_LOW_WORD_I(sa),
    .FIRST_ACCUMULATOR_LOW_HIGH_BYTE_I(f1),
    .FIRST_ACCUMULATOR_LOW_LOW_BYTE_I(l1),
    .BUSY_O(by), .DONE_O(dn), .RESULT_LOGIC_FLAG_O(result_logic_flag),
    .BLOCK_OPEN_I(op), .BLOCK_LEN_I(ln), .BLOCK_RD_O(brd),
    .BLOCK_ADDR_O(ba), .BLOCK_RDATA_I(bd), .FLAG_WR_O(fw),
    .FLAG_ADDR_O(fa), .FLAG_WDATA_O(fd), .IRQ_O(irq)
  );
  dbfc_mem u_mem (.clk_i(clk), .rd_i(brd), .addr_i(ba), .rdata_o(bd));
  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, ra, wd} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdr(input logic [3:0] a, input logic [7:0] e);
    qr.push_back(16'(e));
    @(posedge clk);
    {rd, ra} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
  endtask : rdr
  task automatic go(input logic m, input logic [15:0] s,
    input logic [7:0] f, input logic [7:0] l, input logic o,
    input logic [15:0] n);
    logic [15:0] w;
    logic bad;
    int k;
    bad = !o || l < f || s >= n || s + (l - f) / 2 + 1 > n;
    qd.push_back(16'(bad));
    for (k = 0; !bad && k <= l - f; k++)
    begin
      w = s + 16'(k / 2);
      w = {w[7:0] ^ 8'h5A, w[7:0] ^ 8'hC3};
      qf.push_back({f + 8'(k), (k[0] ^ m) ? w[15:8] : w[7:0]});
    end
    @(posedge clk);
    {st, md, sa, f1, l1, op, ln} <= {1'b1, m, s, f, l, o, n};
    @(posedge clk);
    {st, sa, f1, l1, op, ln} <= {1'b0, ~s, ~f, ~l, ~o, ~n};
    @(posedge clk);
    cmp(16'h1, 16'(by));
    for (k = 0; k < 1000 && dn !== 1'b1; k++)
      @(posedge clk);
    if (k == 1000)
      n_mismatch++;
    cmp(16'h0, 16'(qf.size()));
    $display("test mode %0d start %0d flags %0d-%0d end", m, s, f, l);
  endtask : go
  always @(posedge clk)
  begin
    if (fw === 1'b1)
      cmp(qf.pop_front(), {fa, fd});
    if (dn === 1'b1)
      cmp(qd.pop_front(), 16'(result_logic_flag));
    if (rp)
      cmp(qr.pop_front(), 16'(rq));
    rp <= rd;
  end
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  initial
  begin
    {rst_n, st, md, op, wr, rd, rp, ra, wd, f1, l1, sa, ln} = '0;
    void'($urandom(32'h4a3d4a60));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdr(OFS_CTRL, 8'h1);
    rdr(OFS_MASK, 8'h0);
    rdr(4'hF, 8'h0);
    wrr(OFS_MASK, 8'h2);
    rdr(OFS_MASK, 8'h2);
    go(1'b0, 16'h0, 8'h0, 8'h3, 1'b0, 16'h10);
    rdr(OFS_INFO, 8'h2);
    cmp(16'h1, 16'(irq));
    wrr(OFS_STATUS, 8'h3);
    rdr(OFS_STATUS, 8'h0);
    cmp(16'h0, 16'(irq));
    go(1'b0, 16'h4, 8'hA, 8'hB, 1'b1, 16'h8);
    go(1'b1, 16'h4, 8'hA, 8'hB, 1'b1, 16'h8);
    go(1'b1, 16'h5, 8'h0, 8'h4, 1'b1, 16'h8);
    go(1'b0, 16'h5, 8'h0, 8'h6, 1'b1, 16'h8);
    go(1'b0, 16'h8, 8'h0, 8'h0, 1'b1, 16'h8);
    go(1'b1, 16'h0, 8'h9, 8'h8, 1'b1, 16'h8);
    go(1'b0, 16'h0, 8'h0, 8'hFF, 1'b1, 16'h80);
    repeat (24)
    begin
      rf = 8'($urandom);
      go(1'($urandom), 16'($urandom % 80), rf, rf + 8'($urandom % 40),
        1'($urandom % 8 != 0), 16'($urandom % 100));
    end
    close_out();
  end
endmodule : tb
`default_nettype wire
